// File: irt_transceiver.sv
// infrared transceiver control, status and carrier/cycle engine
`timescale 1ns/100ps
`default_nettype none
`include "irt_defines.svh"

module irt_transceiver
  import irt_pkg::*;
#(
  parameter int PERIOD_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_bus_select,
  input wire logic i_bus_write,
  input wire logic [3:0] i_control_bus_address,
  input wire logic [7:0] i_bus_wdata,
  output logic [7:0] o_bus_rdata,
  input wire logic i_event_trigger,
  input wire logic i_learn,
  input wire logic i_infrared_input,
  output logic o_infrared_output,
  output logic o_busy,
  output logic o_buffer_ready_pin,
  output logic o_error
);

  // refused at elaboration: the divider takes at most a 24-bit denominator
  if (PERIOD_W < 8 || PERIOD_W > 24) begin : g_bad_period_w
    $error("PERIOD_W must lie between 8 and 24");
  end

  //------------------------------------------------------------
  // registers and flags
  //------------------------------------------------------------
  irt_ctrl_s ctrl_ff;
  irt_status_s status;
  irt_state_e state_ff;
  logic [27:0] sys_freq_ff;
  logic [23:0] car_freq_ff;
  logic [7:0] data_hi_ff;
  logic [7:0] data_lo_ff;
  logic busy_ff;
  logic tip_ff;
  logic ready_ff;
  logic fault_ff;
  logic freq_ovf_ff;
  logic cnt_ovf_ff;
  logic freq_valid_ff;
  logic [7:0] rdata_ff;
  logic out_ff;
  logic exe_q_ff;

  logic bus_wr;
  logic bus_rd;
  logic ctrl_wr;
  logic event_start;

  // engine events that act on the flags, the data word and the carrier bytes
  logic set_ready;
  logic set_fault;
  logic set_cnt_ovf;
  logic set_freq_ovf;
  logic set_freq_valid;
  logic store_rec;
  logic [15:0] rec_word;
  logic car_load;
  logic [23:0] car_result;

  assign bus_wr = i_bus_select & i_bus_write;
  assign bus_rd = i_bus_select & ~i_bus_write;
  assign ctrl_wr = bus_wr && (i_control_bus_address == `IRT_ADR_CONTROL);
  assign event_start = i_event_trigger & ~exe_q_ff & ctrl_ff.transceiver_enable;

  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] want);
    is_addr = (a == want);
  endfunction

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      exe_q_ff <= 1'b0;
    end else begin
      exe_q_ff <= i_event_trigger;
    end
  end

  //------------------------------------------------------------
  // host writes
  //------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_ff <= irt_ctrl_s'(`IRT_RESET_BYTE);
      sys_freq_ff <= '0;
    end else if (bus_wr) begin
      if (is_addr(i_control_bus_address, `IRT_ADR_CONTROL)) begin
        ctrl_ff <= irt_ctrl_s'(i_bus_wdata);
      end else if (is_addr(i_control_bus_address, `IRT_ADR_SYS3)) begin
        sys_freq_ff[27:24] <= i_bus_wdata[3:0];
      end else if (is_addr(i_control_bus_address, `IRT_ADR_SYS2)) begin
        sys_freq_ff[23:16] <= i_bus_wdata;
      end else if (is_addr(i_control_bus_address, `IRT_ADR_SYS1)) begin
        sys_freq_ff[15:8] <= i_bus_wdata;
      end else if (is_addr(i_control_bus_address, `IRT_ADR_SYS0)) begin
        sys_freq_ff[7:0] <= i_bus_wdata;
      end
    end
  end

  // carrier bytes: host value, replaced by the measured one in learning
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      car_freq_ff <= '0;
    end else if (car_load) begin
      car_freq_ff <= car_result;
    end else if (bus_wr) begin
      if (is_addr(i_control_bus_address, `IRT_ADR_CAR2)) begin
        car_freq_ff[23:16] <= i_bus_wdata;
      end else if (is_addr(i_control_bus_address, `IRT_ADR_CAR1)) begin
        car_freq_ff[15:8] <= i_bus_wdata;
      end else if (is_addr(i_control_bus_address, `IRT_ADR_CAR0)) begin
        car_freq_ff[7:0] <= i_bus_wdata;
      end
    end
  end

  // data word: a learned record wins over a host write in the same cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      data_hi_ff <= '0;
      data_lo_ff <= '0;
    end else if (store_rec) begin
      data_hi_ff <= rec_word[15:8];
      data_lo_ff <= rec_word[7:0];
    end else if (bus_wr) begin
      if (is_addr(i_control_bus_address, `IRT_ADR_DATA_HI)) begin
        data_hi_ff <= i_bus_wdata;
      end else if (is_addr(i_control_bus_address, `IRT_ADR_DATA_LO)) begin
        data_lo_ff <= i_bus_wdata;
      end
    end
  end

  //------------------------------------------------------------
  // status flags: hardware set wins over any clear
  //------------------------------------------------------------
  logic lo_access;
  assign lo_access = i_bus_select && (i_control_bus_address == `IRT_ADR_DATA_LO)
                     && (i_bus_write == (state_ff != IRT_LEARN));

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ready_ff <= 1'b0;
    end else if (set_ready) begin
      ready_ff <= 1'b1;
    end else if (ctrl_wr || event_start) begin
      ready_ff <= 1'b0;
    end else if (lo_access) begin
      ready_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fault_ff <= 1'b0;
    end else if (set_fault) begin
      fault_ff <= 1'b1;
    end else if (ctrl_wr || event_start) begin
      fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_ovf_ff <= 1'b0;
      freq_ovf_ff <= 1'b0;
    end else begin
      if (set_cnt_ovf) begin
        cnt_ovf_ff <= 1'b1;
      end else if (ctrl_wr || event_start) begin
        cnt_ovf_ff <= 1'b0;
      end
      if (set_freq_ovf) begin
        freq_ovf_ff <= 1'b1;
      end else if (ctrl_wr || event_start) begin
        freq_ovf_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      freq_valid_ff <= 1'b0;
    end else if (set_freq_valid) begin
      freq_valid_ff <= 1'b1;
    end else if (ctrl_wr || event_start) begin
      freq_valid_ff <= 1'b0;
    end
  end

  always_comb begin
    status = '0;
    status.busy = busy_ff;
    status.transfer_in_progress = tip_ff;
    status.freq_counter_overflow = freq_ovf_ff;
    status.cycle_counter_overflow = cnt_ovf_ff;
    status.buffer_fault_flag = fault_ff;
    status.rx_freq_valid = freq_valid_ff;
    status.buffer_ready_flag = ready_ff;
  end

  // read data is registered; write-only and unmapped addresses read zero
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else if (bus_rd) begin
      if (is_addr(i_control_bus_address, `IRT_ADR_CAR2)) begin
        rdata_ff <= car_freq_ff[23:16];
      end else if (is_addr(i_control_bus_address, `IRT_ADR_CAR1)) begin
        rdata_ff <= car_freq_ff[15:8];
      end else if (is_addr(i_control_bus_address, `IRT_ADR_CAR0)) begin
        rdata_ff <= car_freq_ff[7:0];
      end else if (is_addr(i_control_bus_address, `IRT_ADR_DATA_HI)) begin
        rdata_ff <= data_hi_ff;
      end else if (is_addr(i_control_bus_address, `IRT_ADR_DATA_LO)) begin
        rdata_ff <= data_lo_ff;
      end else if (is_addr(i_control_bus_address, `IRT_ADR_STATUS)) begin
        rdata_ff <= status;
      end else begin
        rdata_ff <= '0;
      end
    end
  end

  //------------------------------------------------------------
  // shared restoring divider, 28 quotient bits
  //------------------------------------------------------------
  logic div_start;
  logic [27:0] div_num_in;
  logic [23:0] div_den_in;
  logic div_run_ff;
  logic div_done_ff;
  logic [4:0] div_step_ff;
  logic [27:0] div_q_ff;
  logic [24:0] div_r_ff;
  logic [23:0] div_den_ff;
  logic [24:0] div_trial;

  assign div_trial = {div_r_ff[23:0], div_q_ff[27]};

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      div_run_ff <= 1'b0;
      div_done_ff <= 1'b0;
      div_step_ff <= '0;
      div_q_ff <= '0;
      div_r_ff <= '0;
      div_den_ff <= '0;
    end else begin
      div_done_ff <= 1'b0;
      if (div_start) begin
        div_run_ff <= 1'b1;
        div_step_ff <= '0;
        div_q_ff <= div_num_in;
        div_r_ff <= '0;
        div_den_ff <= div_den_in;
      end else if (div_run_ff) begin
        if (div_trial >= {1'b0, div_den_ff}) begin
          div_r_ff <= div_trial - {1'b0, div_den_ff};
          div_q_ff <= {div_q_ff[26:0], 1'b1};
        end else begin
          div_r_ff <= div_trial;
          div_q_ff <= {div_q_ff[26:0], 1'b0};
        end
        div_step_ff <= div_step_ff + 5'h01;
        if (div_step_ff == `IRT_DIV_STEPS - 5'h01) begin
          div_run_ff <= 1'b0;
          div_done_ff <= 1'b1;
        end
      end
    end
  end

  //------------------------------------------------------------
  // glitch filter on the received signal
  //------------------------------------------------------------
  logic filt_ff;
  logic filt_q_ff;
  logic [3:0] filt_cnt_ff;
  logic [3:0] filt_win;

  always_comb begin
    case (ctrl_ff.glitch_filter_select)
      2'b01: filt_win = `IRT_FILT_W1;
      2'b10: filt_win = `IRT_FILT_W2;
      2'b11: filt_win = `IRT_FILT_W3;
      default: filt_win = 4'h1;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      filt_ff <= 1'b0;
      filt_q_ff <= 1'b0;
      filt_cnt_ff <= '0;
    end else begin
      filt_q_ff <= filt_ff;
      if (i_infrared_input == filt_ff) begin
        filt_cnt_ff <= '0;
      end else if (filt_cnt_ff + 4'h1 >= filt_win) begin
        filt_ff <= i_infrared_input;
        filt_cnt_ff <= '0;
      end else begin
        filt_cnt_ff <= filt_cnt_ff + 4'h1;
      end
    end
  end

  //------------------------------------------------------------
  // transmit and learning engine
  //------------------------------------------------------------
  logic [27:0] period_ff;
  logic [27:0] phase_ff;
  logic cur_on_ff;
  logic [14:0] cur_cnt_ff;
  logic [14:0] fetch_cnt;
  logic [29:0] duty_prod;
  logic carrier_on;
  logic in_rise;
  logic [PERIOD_W-1:0] meas_ff;
  logic [PERIOD_W-1:0] per_meas_ff;
  logic [PERIOD_W-1:0] off_tmr_ff;
  logic have_edge_ff;
  logic group_on_ff;
  logic per_valid_ff;
  logic first_done_ff;
  logic [14:0] elem_ff;
  logic [14:0] max_cnt_ff;
  logic gap;

  assign fetch_cnt = ({data_hi_ff[6:0], data_lo_ff} == 15'h0000) ? 15'h0001
                     : {data_hi_ff[6:0], data_lo_ff};
  assign duty_prod = ctrl_ff.third_duty_select ? ({2'b00, phase_ff} + {1'b0, phase_ff, 1'b0})
                     : {1'b0, phase_ff, 1'b0};
  assign carrier_on = cur_on_ff && (duty_prod < {2'b00, period_ff});
  assign in_rise = filt_ff & ~filt_q_ff;
  assign gap = group_on_ff && first_done_ff && have_edge_ff
               && ({1'b0, meas_ff} >= {per_meas_ff, 1'b0});

  always_comb begin
    div_start = 1'b0;
    div_num_in = sys_freq_ff;
    div_den_in = car_freq_ff;
    set_ready = 1'b0;
    set_fault = 1'b0;
    set_cnt_ovf = 1'b0;
    set_freq_ovf = 1'b0;
    set_freq_valid = 1'b0;
    store_rec = 1'b0;
    rec_word = '0;
    car_load = 1'b0;
    car_result = div_q_ff[23:0];
    if (event_start && !i_learn) begin
      div_start = 1'b1;
    end
    case (state_ff)
      IRT_CALC: begin
        set_ready = div_done_ff;
      end
      IRT_TX: begin
        if (phase_ff >= period_ff - 28'h1 && cur_cnt_ff == 15'h0001 && i_event_trigger) begin
          set_ready = 1'b1;
          set_fault = ready_ff;
        end
      end
      IRT_LEARN: begin
        if (div_done_ff) begin
          car_load = 1'b1;
          set_freq_valid = 1'b1;
        end
        if (have_edge_ff && meas_ff == {PERIOD_W{1'b1}} && !gap) begin
          set_freq_ovf = 1'b1;
        end
        if (in_rise && group_on_ff && !per_valid_ff && have_edge_ff
            && (ctrl_ff.repeat_measure_enable || !first_done_ff)) begin
          div_start = 1'b1;
          div_den_in = 24'(meas_ff) + 24'h1;
        end
        if ((in_rise && !group_on_ff && elem_ff != 15'h0000) || gap) begin
          store_rec = 1'b1;
          rec_word = {gap, elem_ff};
          set_ready = 1'b1;
          set_fault = ready_ff;
        end
        if (elem_ff == max_cnt_ff && (in_rise || off_tmr_ff == per_meas_ff)) begin
          set_cnt_ovf = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= IRT_IDLE;
      period_ff <= '0;
      phase_ff <= '0;
      cur_on_ff <= 1'b0;
      cur_cnt_ff <= '0;
    end else if (!ctrl_ff.transceiver_enable) begin
      state_ff <= IRT_IDLE;
      cur_on_ff <= 1'b0;
    end else begin
      case (state_ff)
        IRT_IDLE: begin
          if (event_start) begin
            state_ff <= i_learn ? IRT_LEARN : IRT_CALC;
          end
        end
        IRT_CALC: begin
          if (div_done_ff) begin
            period_ff <= (div_q_ff == 28'h0) ? 28'h1 : div_q_ff;
            phase_ff <= '0;
            cur_on_ff <= data_hi_ff[`IRT_MARKER_BIT];
            cur_cnt_ff <= fetch_cnt;
            state_ff <= IRT_TX;
          end
        end
        IRT_TX: begin
          if (phase_ff >= period_ff - 28'h1) begin
            phase_ff <= '0;
            if (cur_cnt_ff != 15'h0001) begin
              cur_cnt_ff <= cur_cnt_ff - 15'h0001;
            end else if (!i_event_trigger) begin
              state_ff <= IRT_IDLE;
              cur_on_ff <= 1'b0;
            end else begin
              // an under-run replays the stale word so the carrier keeps its timing
              cur_on_ff <= data_hi_ff[`IRT_MARKER_BIT];
              cur_cnt_ff <= fetch_cnt;
            end
          end else begin
            phase_ff <= phase_ff + 28'h1;
          end
        end
        IRT_LEARN: begin
          if (!i_event_trigger) begin
            state_ff <= IRT_IDLE;
          end
        end
        default: begin
          state_ff <= IRT_IDLE;
        end
      endcase
    end
  end

  // learning measurement: carrier period between rising edges, ON/OFF cycle counts
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meas_ff <= '0;
      per_meas_ff <= '0;
      off_tmr_ff <= '0;
      have_edge_ff <= 1'b0;
      group_on_ff <= 1'b0;
      per_valid_ff <= 1'b0;
      first_done_ff <= 1'b0;
      elem_ff <= '0;
      max_cnt_ff <= `IRT_MAX_COUNT;
    end else if (state_ff != IRT_LEARN) begin
      meas_ff <= '0;
      have_edge_ff <= 1'b0;
      group_on_ff <= 1'b0;
      per_valid_ff <= 1'b0;
      first_done_ff <= 1'b0;
      elem_ff <= '0;
      off_tmr_ff <= '0;
      max_cnt_ff <= ctrl_ff.user_max_count_select ? {data_hi_ff[6:0], data_lo_ff}
                    : `IRT_MAX_COUNT;
    end else if (in_rise) begin
      meas_ff <= '0;
      have_edge_ff <= 1'b1;
      off_tmr_ff <= '0;
      if (group_on_ff) begin
        if (elem_ff != max_cnt_ff) begin
          elem_ff <= elem_ff + 15'h0001;
        end
        if (!per_valid_ff && have_edge_ff) begin
          per_meas_ff <= meas_ff + 1'b1;
          per_valid_ff <= 1'b1;
          first_done_ff <= 1'b1;
        end
      end else begin
        group_on_ff <= 1'b1;
        per_valid_ff <= 1'b0;
        elem_ff <= 15'h0001;
      end
    end else if (gap) begin
      // carrier lost for two periods: the ON group ends, OFF counting starts
      group_on_ff <= 1'b0;
      have_edge_ff <= 1'b0;
      meas_ff <= '0;
      elem_ff <= 15'h0001;
      off_tmr_ff <= '0;
    end else if (have_edge_ff) begin
      if (meas_ff == {PERIOD_W{1'b1}}) begin
        have_edge_ff <= 1'b0;
        meas_ff <= '0;
      end else begin
        meas_ff <= meas_ff + 1'b1;
      end
    end else if (!group_on_ff && first_done_ff && elem_ff != 15'h0000) begin
      if (off_tmr_ff == per_meas_ff) begin
        off_tmr_ff <= '0;
        if (elem_ff != max_cnt_ff) begin
          elem_ff <= elem_ff + 15'h0001;
        end
      end else begin
        off_tmr_ff <= off_tmr_ff + 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // pins
  //------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      tip_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != IRT_IDLE) || div_run_ff;
      tip_ff <= (state_ff == IRT_TX) || (state_ff == IRT_LEARN);
      if (state_ff == IRT_TX && !(fault_ff && ctrl_ff.stop_output_on_fault)) begin
        out_ff <= carrier_on ^ ctrl_ff.output_polarity_select;
      end else begin
        out_ff <= ctrl_ff.output_polarity_select;
      end
    end
  end

  assign o_bus_rdata = rdata_ff;
  assign o_infrared_output = out_ff;
  assign o_busy = busy_ff;
  assign o_buffer_ready_pin = ready_ff;
  assign o_error = fault_ff;

endmodule
`default_nettype wire

// File: irt_defines.svh
// register map, field positions, reset values and counts of the infrared transceiver
//------------------------------------------------------------
// Notes on behaviour
// - four-bit address: control 1, sysclk 2-5, carrier 6-8, data 9-a, status b
// - control bit 7 enables the transceiver; clear keeps it disabled
// - control bit 6 picks ON duty: half period at 0, third at 1
// - control bit 5 picks pulse polarity: high active at 0, low active at 1
// - control bit 4 set gates the transmit output off after an error
// - control bit 3 picks learn max count: 7fff or user value from data
// - control bit 2 re-measures carrier every ON group, else only the first
// - control bits 1:0 pick glitch filter: none, 2, 4 or 8 clocks
// - status: busy, in progress, zero, freq ovf, count ovf, error, freq ready, buf ready
// - busy flag marks tx, rx or calculation; busy pin equals the flag
// - in transmit, fetching data sets buffer ready
// - in transmit, host write of low data byte clears buffer ready
// - data not rewritten when an element ends sets the error flag
// - error flag holds until control write or new event start
// - in learning, buffer ready marks a result; low byte read clears it
// - in learning, unread data when next result lands sets the error flag
// - ready pin mirrors buffer ready, error pin mirrors error flag
// - control write or new event clears buffer ready
// - cycle counter at maximum sets count overflow until control write or event
// - period counter past 16 bits sets freq overflow, drops edge, restarts
// - learning sets freq ready once the carrier frequency is computed
// - four bytes hold 28-bit system frequency; top nibble of byte 3 ignored
// - three bytes hold 24-bit carrier frequency; period is sys over carrier
// - data bit 15 marks ON/OFF, bits 14:0 count; zero count means one
//------------------------------------------------------------
`ifndef IRT_DEFINES_SVH
`define IRT_DEFINES_SVH

`define IRT_ADR_CONTROL 4'h1
`define IRT_ADR_SYS3 4'h2
`define IRT_ADR_SYS2 4'h3
`define IRT_ADR_SYS1 4'h4
`define IRT_ADR_SYS0 4'h5
`define IRT_ADR_CAR2 4'h6
`define IRT_ADR_CAR1 4'h7
`define IRT_ADR_CAR0 4'h8
`define IRT_ADR_DATA_HI 4'h9
`define IRT_ADR_DATA_LO 4'ha
`define IRT_ADR_STATUS 4'hb

`define IRT_RESET_BYTE 8'h00
`define IRT_MAX_COUNT 15'h7fff
`define IRT_MARKER_BIT 7
`define IRT_FILT_W1 4'h2
`define IRT_FILT_W2 4'h4
`define IRT_FILT_W3 4'h8
`define IRT_DIV_STEPS 5'h1c

`endif

// File: irt_pkg.sv
// types shared by the infrared transceiver register block
`default_nettype none
package irt_pkg;

  typedef enum logic [3:0] {
    IRT_IDLE  = 4'b0001,
    IRT_CALC  = 4'b0010,
    IRT_TX    = 4'b0100,
    IRT_LEARN = 4'b1000
  } irt_state_e;

  typedef struct packed {
    logic transceiver_enable;
    logic third_duty_select;
    logic output_polarity_select;
    logic stop_output_on_fault;
    logic user_max_count_select;
    logic repeat_measure_enable;
    logic [1:0] glitch_filter_select;
  } irt_ctrl_s;

  typedef struct packed {
    logic busy;
    logic transfer_in_progress;
    logic reserved;
    logic freq_counter_overflow;
    logic cycle_counter_overflow;
    logic buffer_fault_flag;
    logic rx_freq_valid;
    logic buffer_ready_flag;
  } irt_status_s;

endpackage
`default_nettype wire

// File: irt_ir_source.sv
// carrier source standing in for the remote infrared emitter
`timescale 1ns/100ps
`default_nettype none
module irt_ir_source #(parameter int HALF = 5) (
  input wire logic i_clock,
  input wire logic i_on,
  output logic o_ir
);
  int cnt = 0;
  // dark between bursts, like a receiver with nothing in view
  initial o_ir = 1'b0;
  always @(posedge i_clock) begin
    cnt <= (!i_on || cnt == 2*HALF-1) ? 0 : cnt + 1;
    o_ir <= i_on && (cnt < HALF);
  end
endmodule
`default_nettype wire

// File: irt_transceiver_sva.sv
// port checks of the infrared transceiver
`timescale 1ns/100ps
`default_nettype none
module irt_transceiver_sva (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_bus_select,
  input wire logic i_bus_write,
  input wire logic [3:0] i_control_bus_address,
  input wire logic [7:0] i_bus_wdata,
  input wire logic [7:0] o_bus_rdata,
  input wire logic i_event_trigger,
  input wire logic i_learn,
  input wire logic o_infrared_output,
  input wire logic o_busy,
  input wire logic o_buffer_ready_pin,
  input wire logic o_error
);
  // ----
  // helpers
  // ----
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic t1, t2, ctl_wr, rd_req, rise_near;
  logic [7:0] ctl_q;
  // shadow of the control byte, loaded on the same edge as the block's own copy
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) ctl_q <= 8'h00;
    else if (ctl_wr) ctl_q <= i_bus_wdata;
  end
  assign ctl_wr = i_bus_select && i_bus_write && i_control_bus_address == 4'h1;
  assign rd_req = i_bus_select && !i_bus_write;
  // a start may be seen up to one edge late inside the block
  assign rise_near = (i_event_trigger && !t1) || (t1 && !t2);
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) {t2, t1} <= 2'h0;
    else {t2, t1} <= {t1, i_event_trigger};
  end
  sequence ctl_off;
    ctl_wr && !i_bus_wdata[7] ##1 !ctl_wr [*2];
  endsequence
  a_rdata_holds: assert property (!rd_req |=> $stable(o_bus_rdata))
    else $error("read data moved without a read");
  a_wo_reads_zero: assert property (rd_req && (i_control_bus_address < 4'h6 ||
    i_control_bus_address > 4'hb) |=> o_bus_rdata == 8'h00)
    else $error("write-only or unmapped read not zero");
  a_status_mirror: assert property (rd_req && i_control_bus_address == 4'hb |=>
    o_bus_rdata[7] == $past(o_busy) && o_bus_rdata[2] == $past(o_error) &&
    o_bus_rdata[0] == $past(o_buffer_ready_pin) && !o_bus_rdata[5])
    else $error("status byte differs from pins");
  a_ctl_clears: assert property (ctl_wr && !i_bus_wdata[7] |=>
    !o_buffer_ready_pin && !o_error)
    else $error("control write left flags set");
  a_off_not_busy: assert property (ctl_off |=> !o_busy)
    else $error("busy while disabled");
  a_idle_polarity: assert property (ctl_off |=>
    o_infrared_output == $past(i_bus_wdata[5], 3))
    else $error("idle output level wrong");
  a_fault_sticky: assert property (o_error && !ctl_wr && !rise_near |=> o_error)
    else $error("error flag dropped early");
  a_low_wr_clears: assert property (i_bus_select && i_bus_write && !i_learn &&
    i_control_bus_address == 4'ha |=> !o_buffer_ready_pin)
    else $error("low data write kept ready");
  a_reset_quiet: assert property ($fell(i_rst) |-> !o_busy && !o_error &&
    !o_buffer_ready_pin && o_bus_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  a_fault_gates_out: assert property (o_error && ctl_q[4] |=>
    o_infrared_output == $past(ctl_q[5]))
    else $error("output not gated after error");
endmodule
bind irt_transceiver irt_transceiver_sva chk (.i_clock, .i_rst, .i_bus_select, .i_bus_write,
  .i_control_bus_address, .i_bus_wdata, .o_bus_rdata, .i_event_trigger, .i_learn,
  .o_infrared_output, .o_busy, .o_buffer_ready_pin, .o_error);
`default_nettype wire

// File: irt_transceiver_test.sv
// self-checking bench for the infrared transceiver
`timescale 1ns/100ps
`default_nettype none
module irt_transceiver_test;
  import irt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, wr = 1'b0, trig = 1'b0, learn = 1'b0;
  logic src_on = 1'b0, infrared_input, infrared_output, busy, rdy, err;
  logic [3:0] adr = 4'h0;
  logic [7:0] wd = 8'h00, rdata;
  logic [11:0] cfg [10] = '{12'h2f0, 12'h300, 12'h400, 12'h528, 12'h600, 12'h700,
    12'h804, 12'h980, 12'ha03, 12'h190};
  int miscompares = 0, samples_checked = 0;
  irt_status_s st;
  irt_transceiver dut (.i_clock(clk), .i_rst(rst), .i_bus_select(sel), .i_bus_write(wr),
    .i_control_bus_address(adr), .i_bus_wdata(wd), .o_bus_rdata(rdata),
    .i_event_trigger(trig), .i_learn(learn), .i_infrared_input(infrared_input),
    .o_infrared_output(infrared_output), .o_busy(busy), .o_buffer_ready_pin(rdy), .o_error(err));
  irt_ir_source src (.i_clock(clk), .i_on(src_on), .o_ir(infrared_input));
  // ----
  // access and compare tasks
  // ----
  initial forever #12.5 clk = ~clk;
  task automatic cmp(input logic [7:0] got, exp, msk);
    samples_checked++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {sel, wr, adr, wd} = {1'b1, w, a, d};
    @(negedge clk);
    sel = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, msk);
    acc(1'b0, a, 8'h00);
    cmp(rdata, exp, msk);
  endtask
  // bounded wait on a pin, then compare it
  task automatic wait_for(ref logic s, input logic v);
    for (int n = 0; n < 400 && s !== v; n++) @(negedge clk);
    cmp({7'h0, s}, {7'h0, v}, 8'h01);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    miscompares++;
    report_and_stop();
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int a = 1; a < 16; a += 4) rd(a[3:0], 8'h00, 8'hff);
    rd(4'hb, 8'h00, 8'hff);
    acc(1'b1, 4'h1, 8'h20);
    repeat (3) @(negedge clk);
    cmp({7'h0, infrared_output}, 8'h01, 8'h01);
    $display("idle test done");
    foreach (cfg[i]) acc(1'b1, cfg[i][11:8], cfg[i][7:0]);
    rd(4'h8, 8'h04, 8'hff);
    rd(4'h9, 8'h80, 8'hff);
    trig = 1'b1;
    wait_for(rdy, 1'b1);
    rd(4'hb, 8'hc1, 8'hc5);
    wait_for(infrared_output, 1'b1);
    acc(1'b1, 4'ha, 8'h00);
    cmp({7'h0, rdy}, 8'h00, 8'h01);
    wait_for(rdy, 1'b1);
    wait_for(err, 1'b1);
    repeat (12) @(negedge clk) cmp({7'h0, infrared_output}, 8'h00, 8'h01);
    rd(4'hb, 8'h04, 8'h04);
    trig = 1'b0;
    wait_for(busy, 1'b0);
    cmp({7'h0, err}, 8'h01, 8'h01);
    acc(1'b1, 4'h1, 8'h81);
    cmp({6'h0, err, rdy}, 8'h00, 8'h03);
    $display("transmit test done");
    learn = 1'b1;
    src_on = 1'b1;
    trig = 1'b1;
    st = '0;
    for (int n = 0; n < 80 && !st.rx_freq_valid; n++) begin
      acc(1'b0, 4'hb, 8'h00);
      st = rdata;
    end
    cmp(st, 8'h02, 8'h02);
    rd(4'h8, 8'h04, 8'hff);
    src_on = 1'b0;
    wait_for(rdy, 1'b1);
    rd(4'h9, 8'h80, 8'hff);
    rd(4'ha, 8'h00, 8'h00);
    cmp({7'h0, rdy}, 8'h00, 8'h01);
    src_on = 1'b1;
    repeat (60) @(negedge clk);
    src_on = 1'b0;
    wait_for(err, 1'b1);
    trig = 1'b0;
    $display("learning test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
